// [bench/dmacre_far_model.sv]
// Model of the peripherals and the transfer engine beside the control block.
`timescale 1ns/1ps
`default_nettype none

module dmacre_far_model (
  input wire logic clk, // Clock.
  output var logic [dmacre_pkg::CHAN_COUNT-1:0] single_req, // Single requests.
  output var logic [dmacre_pkg::CHAN_COUNT-1:0] burst_req, // Burst requests.
  output var dmacre_pkg::dmacre_engine_evt_t evt // Engine event.
);
  import dmacre_pkg::*;
  initial begin
    single_req = 10'h000;
    burst_req = 10'h000;
    evt = '0;
  end
  // Peripheral requests are levels held until the next call.
  task automatic request(input logic [9:0] s, input logic [9:0] b);
    @(posedge clk);
    single_req <= s;
    burst_req <= b;
  endtask : request
  // The engine reports an event for exactly one cycle.
  task automatic pulse(input dmacre_engine_evt_t e);
    @(posedge clk);
    evt <= e;
    @(posedge clk);
    evt <= '0;
  endtask : pulse
endmodule : dmacre_far_model

`default_nettype wire

// [bench/dmacre_properties.sv]
// Checker of the channel control block's port behaviour.
`timescale 1ns/1ps
`default_nettype none

module dmacre_properties (
  input wire logic CLK, // Clock.
  input wire logic RST_N, // Reset.
  input wire logic CYC_I, // Cycle.
  input wire logic STB_I, // Strobe.
  input wire logic WE_I, // Write.
  input wire logic [dmacre_pkg::ADDR_W-1:0] ADR_I, // Address.
  input wire logic [dmacre_pkg::SEL_W-1:0] SEL_I, // Lanes.
  input wire logic [dmacre_pkg::DATA_W-1:0] DAT_I, // Write data.
  input wire logic [dmacre_pkg::DATA_W-1:0] DAT_O, // Read data.
  input wire logic ACK_O, // Acknowledge.
  input wire dmacre_pkg::dmacre_engine_evt_t ENGINE_EVT, // Engine event.
  input wire logic [dmacre_pkg::CHAN_COUNT-1:0] CHAN_ENABLE, // Enables.
  input wire logic [dmacre_pkg::CHAN_COUNT-1:0] CHAN_REQ_MASK, // Masks.
  input wire logic [dmacre_pkg::CHAN_COUNT-1:0] SW_REQ_PULSE // Software pulses.
);
  import dmacre_pkg::*;
  logic wr;
  logic rd;
  logic stop;
  logic [CHAN_COUNT-1:0] wm;
  logic [CHAN_COUNT-1:0] kill;
  assign wr = CYC_I & STB_I & WE_I & ACK_O;
  assign rd = CYC_I & STB_I & !WE_I & ACK_O;
  assign wm = DAT_I[9:0] & {{2{SEL_I[1]}}, {8{SEL_I[0]}}};
  assign stop = ENGINE_EVT.desc_valid & (ENGINE_EVT.desc_ctrl == CYCLE_CTRL_STOP);
  // A software enable set in the same cycle wins over the engine event.
  assign kill = (ENGINE_EVT.chan > 4'h9 || (wr && ADR_I == ADDR_CHAN_ENABLE_SET)) ? 10'h000 :
    {9'h000, ENGINE_EVT.cycle_done | stop | ENGINE_EVT.bus_err} << ENGINE_EVT.chan;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  AST_ACK_ONE: assert property (ACK_O |=> !ACK_O)
    else $error("ack held longer than one cycle");
  AST_ACK_NEXT: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O)
    else $error("request not answered in one cycle");
  AST_SW_PULSE: assert property (
    1'b1 |=> SW_REQ_PULSE == $past(wr && ADR_I == ADDR_SW_REQ_TRIGGER ? wm : 10'h000))
    else $error("software pulse differs from written ones");
  AST_MASK_SET: assert property (
    wr && ADR_I == ADDR_PREQ_MASK_SET |->
    ##2 CHAN_REQ_MASK == ($past(CHAN_REQ_MASK, 2) | $past(wm, 2)))
    else $error("mask set write wrong");
  AST_MASK_CLR: assert property (
    wr && ADR_I == ADDR_PREQ_MASK_CLEAR |->
    ##2 CHAN_REQ_MASK == ($past(CHAN_REQ_MASK, 2) & ~$past(wm, 2)))
    else $error("mask clear write wrong");
  AST_EN_SET: assert property (
    wr && ADR_I == ADDR_CHAN_ENABLE_SET |-> ##2 (CHAN_ENABLE & $past(wm, 2)) == $past(wm, 2))
    else $error("enable set write did not enable");
  AST_EN_CLR: assert property (
    wr && ADR_I == ADDR_CHAN_ENABLE_CLEAR |-> ##2 (CHAN_ENABLE & $past(wm, 2)) == 10'h000)
    else $error("enable clear write did not disable");
  AST_AUTO_OFF: assert property (
    kill != 10'h000 |-> ##2 (CHAN_ENABLE & $past(kill, 2)) == 10'h000)
    else $error("engine event did not disable channel");
  AST_RD_ENABLE: assert property (
    rd && ADR_I == ADDR_CHAN_ENABLE_SET |-> DAT_O == {22'h00_0000, CHAN_ENABLE})
    else $error("enable read differs from state");
  AST_RD_MASK: assert property (
    rd && ADR_I == ADDR_PREQ_MASK_SET |-> DAT_O == {22'h00_0000, CHAN_REQ_MASK})
    else $error("mask read differs from state");
endmodule : dmacre_properties

bind dmacre_ctrl dmacre_properties i_dmacre_properties (.CLK, .RST_N, .CYC_I, .STB_I, .WE_I,
  .ADR_I, .SEL_I, .DAT_I, .DAT_O, .ACK_O, .ENGINE_EVT, .CHAN_ENABLE, .CHAN_REQ_MASK,
  .SW_REQ_PULSE);

`default_nettype wire

// [bench/tb.sv]
// Self-checking testbench of the channel request and enable control block.
`timescale 1ns/1ps
`default_nettype none

module tb;
  import dmacre_pkg::*;
  localparam logic [31:0] Z = 32'h0000_0000;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic ack;
  logic [3:0] sel = 4'h0;
  logic [31:0] adr = Z;
  logic [31:0] dat_w = Z;
  logic [31:0] dat_r;
  logic [9:0] psingle, pburst, chan_en, chan_mask, sw_pulse;
  dmacre_engine_evt_t evt;
  dmacre_req_t chan_req;
  int miscompares = 0;
  int num_checks = 0;

  always #2.5 clk = ~clk;

  dmacre_far_model i_dmacre_far_model (.clk(clk), .single_req(psingle), .burst_req(pburst),
    .evt(evt));
  dmacre_ctrl i_dmacre_ctrl (.CLK(clk), .RST_N(rst_n), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
    .ADR_I(adr), .SEL_I(sel), .DAT_I(dat_w), .DAT_O(dat_r), .ACK_O(ack),
    .PERIPH_SINGLE_REQ(psingle), .PERIPH_BURST_REQ(pburst), .ENGINE_EVT(evt),
    .CHAN_REQ(chan_req), .CHAN_ENABLE(chan_en), .CHAN_REQ_MASK(chan_mask),
    .SW_REQ_PULSE(sw_pulse));

  // ----------------------------------------------------------------------------
  // Bus and compare helpers
  // ----------------------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
    input logic [3:0] s, output logic [31:0] q);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= d;
    sel <= s;
    // Only the watchdog ends a wait for an acknowledge that never comes.
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : bus

  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] q;
    bus(1'b1, a, d, s, q);
  endtask : wr

  task automatic rdchk(input string what, input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, Z, 4'hF, q);
    check(what, q, exp);
  endtask : rdchk

  // ----------------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------------
  task automatic t_reset();
    rdchk("mask reset", ADDR_PREQ_MASK_SET, Z);
    rdchk("enable reset", ADDR_CHAN_ENABLE_SET, Z);
    rdchk("unmapped read", 32'h4003_6018, Z);
    rdchk("clear reads zero", ADDR_PREQ_MASK_CLEAR, Z);
  endtask : t_reset

  task automatic t_swreq();
    wr(ADDR_SW_REQ_TRIGGER, 32'h0000_0201, 4'hF);
    #1;
    check("sw pulse", sw_pulse, 32'h0000_0201);
    @(posedge clk);
    #1;
    check("sw pulse end", sw_pulse, Z);
    check("sw burst", chan_req.burst_req, 32'h0000_0201);
    wr(ADDR_SW_REQ_TRIGGER, Z, 4'hF);
    #1;
    check("sw zero", sw_pulse, Z);
  endtask : t_swreq

  task automatic t_mask();
    i_dmacre_far_model.request(10'h3FF, 10'h3FF);
    wr(ADDR_PREQ_MASK_SET, 32'h0000_03A5, 4'h1);
    rdchk("mask lane", ADDR_PREQ_MASK_SET, 32'h0000_00A5);
    wr(ADDR_PREQ_MASK_SET, Z, 4'hF);
    rdchk("mask keep", ADDR_PREQ_MASK_SET, 32'h0000_00A5);
    check("single masked", chan_req.single_req, 32'h0000_035A);
    check("burst masked", chan_req.burst_req, 32'h0000_035A);
    wr(ADDR_PREQ_MASK_CLEAR, 32'h0000_0005, 4'hF);
    repeat (3) @(posedge clk);
    check("single unmasked", chan_req.single_req, 32'h0000_035F);
    rdchk("mask cleared", ADDR_PREQ_MASK_SET, 32'h0000_00A0);
    wr(ADDR_PREQ_MASK_CLEAR, 32'h0000_00A0, 4'hF);
    i_dmacre_far_model.request(10'h000, 10'h000);
  endtask : t_mask

  task automatic t_enable();
    wr(ADDR_CHAN_ENABLE_SET, 32'h0000_03FF, 4'hF);
    rdchk("enable set", ADDR_CHAN_ENABLE_SET, 32'h0000_03FF);
    wr(ADDR_CHAN_ENABLE_SET, Z, 4'hF);
    wr(ADDR_CHAN_ENABLE_CLEAR, 32'h0000_0201, 4'hF);
    rdchk("enable clear", ADDR_CHAN_ENABLE_SET, 32'h0000_01FE);
    wr(ADDR_CHAN_ENABLE_CLEAR, Z, 4'hF);
    check("enable port", chan_en, 32'h0000_01FE);
  endtask : t_enable

  task automatic t_auto();
    dmacre_engine_evt_t ev [5];
    logic [9:0] ex [5];
    // Done, stop descriptor, live descriptor, bus error, out-of-range channel.
    ev = '{'{1'b1, 1'b0, 3'h0, 1'b0, 4'h1}, '{1'b0, 1'b1, 3'h0, 1'b0, 4'h2},
      '{1'b0, 1'b1, 3'h1, 1'b0, 4'h3}, '{1'b0, 1'b0, 3'h0, 1'b1, 4'h4},
      '{1'b1, 1'b0, 3'h0, 1'b0, 4'hC}};
    ex = '{10'h1FC, 10'h1F8, 10'h1F8, 10'h1E8, 10'h1E8};
    foreach (ev[i]) begin
      i_dmacre_far_model.pulse(ev[i]);
      repeat (2) @(posedge clk);
      #1;
      check("auto disable", chan_en, ex[i]);
    end
    rdchk("auto read", ADDR_CHAN_ENABLE_SET, 32'h0000_01E8);
    rdchk("auto flags", ADDR_AUTO_DIS_FLAGS, 32'h0000_0016);
    rdchk("auto cause", ADDR_AUTO_DIS_CAUSE, 32'h0000_0043);
    wr(ADDR_AUTO_DIS_FLAGS, 32'h0000_0016, 4'hF);
    rdchk("flags cleared", ADDR_AUTO_DIS_FLAGS, Z);
  endtask : t_auto

  task automatic t_rereset();
    wr(ADDR_PREQ_MASK_SET, 32'h0000_0003, 4'hF);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    check("enable after reset", chan_en, Z);
    check("mask after reset", chan_mask, Z);
    rdchk("mask read after reset", ADDR_PREQ_MASK_SET, Z);
  endtask : t_rereset

  task automatic summarize();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : summarize

  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_swreq();
    t_mask();
    t_enable();
    t_auto();
    t_rereset();
    summarize();
  end

  // The sequence needs about 110 cycles; over thirty times that means a hang.
  initial begin
    repeat (4000) @(posedge clk);
    miscompares++;
    summarize();
  end
endmodule : tb

`default_nettype wire

// [verilog/dmacre_chan_cell.sv]
// One channel's enable, peripheral request mask, auto-disable flag and request outputs.
`timescale 1ns/1ps
`default_nettype none

module dmacre_chan_cell (
  input wire logic CLK, // System clock.
  input wire logic RST_N, // Asynchronous reset, active low.
  input wire logic enable_set, // Software writes one to the enable set bit.
  input wire logic enable_clear, // Software writes one to the enable clear bit.
  input wire logic auto_disable, // Engine event that ends this channel.
  input wire logic mask_set, // Software writes one to the mask set bit.
  input wire logic mask_clear, // Software writes one to the mask clear bit.
  input wire logic flag_clear, // Software clears the auto-disable flag.
  input wire logic sw_trigger, // One-cycle software request.
  input wire logic periph_single, // Peripheral single request.
  input wire logic periph_burst, // Peripheral burst request.
  output logic enable_reg, // Channel enabled.
  output logic mask_reg, // Peripheral requests blocked.
  output logic flag_reg, // Channel was disabled by the engine.
  output logic single_reg, // Accepted single request.
  output logic burst_reg // Accepted burst request.
);
  import dmacre_pkg::*;

  // ----------------------------------------------------------------------------
  // Enable state
  // ----------------------------------------------------------------------------
  // A software set in the same cycle as any disable wins, so the write is not lost.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      enable_reg <= 1'b0;
    end else if (enable_set) begin
      enable_reg <= 1'b1;
    end else if (enable_clear || auto_disable) begin
      enable_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------------
  // Peripheral request mask
  // ----------------------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      mask_reg <= 1'b0;
    end else if (mask_set) begin
      mask_reg <= 1'b1;
    end else if (mask_clear) begin
      mask_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------------
  // Auto-disable flag, the engine's set wins over a software clear
  // ----------------------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      flag_reg <= 1'b0;
    end else if (auto_disable) begin
      flag_reg <= 1'b1;
    end else if (flag_clear) begin
      flag_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------------
  // Requests towards the arbiter
  // ----------------------------------------------------------------------------
  // Software requests are burst requests and bypass the peripheral mask.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      single_reg <= 1'b0;
      burst_reg <= 1'b0;
    end else begin
      single_reg <= periph_single & ~mask_reg;
      burst_reg <= (periph_burst & ~mask_reg) | sw_trigger;
    end
  end

endmodule : dmacre_chan_cell

`default_nettype wire

// [verilog/dmacre_ctrl.sv]
// Top of the DMA channel request and enable control block with its Wishbone register file.
//
// Operation
// - A written one in the software trigger raises that channel's data request.
// - Mask set register reads one for blocked channels, zero for accepted ones.
// - Writing one to mask set blocks that channel's peripheral requests; zero does nothing.
// - Writing one to mask clear unblocks the channel's peripheral requests; zero does nothing.
// - Enable set register reads one for enabled channels, zero for disabled ones.
// - Writing one to enable set enables the channel; zero never disables.
// - A channel is disabled by hardware when its DMA cycle completes.
// - A fetched descriptor with cycle control zero disables that channel.
// - An error response on the memory bus disables the active channel.
// - Writing one to enable clear disables the channel; zero changes nothing.
`timescale 1ns/1ps
`default_nettype none

module dmacre_ctrl (
  input wire logic CLK, // System clock, 200 MHz.
  input wire logic RST_N, // Asynchronous reset, active low.
  input wire logic CYC_I, // Wishbone cycle.
  input wire logic STB_I, // Wishbone strobe.
  input wire logic WE_I, // Wishbone write enable.
  input wire logic [dmacre_pkg::ADDR_W-1:0] ADR_I, // Wishbone byte address.
  input wire logic [dmacre_pkg::SEL_W-1:0] SEL_I, // Wishbone byte lane selects.
  input wire logic [dmacre_pkg::DATA_W-1:0] DAT_I, // Wishbone write data.
  output logic [dmacre_pkg::DATA_W-1:0] DAT_O, // Wishbone read data.
  output logic ACK_O, // Wishbone acknowledge.
  input wire logic [dmacre_pkg::CHAN_COUNT-1:0] PERIPH_SINGLE_REQ, // Peripheral single requests.
  input wire logic [dmacre_pkg::CHAN_COUNT-1:0] PERIPH_BURST_REQ, // Peripheral burst requests.
  input wire dmacre_pkg::dmacre_engine_evt_t ENGINE_EVT, // Engine events for one channel.
  output dmacre_pkg::dmacre_req_t CHAN_REQ, // Accepted requests to the arbiter.
  output logic [dmacre_pkg::CHAN_COUNT-1:0] CHAN_ENABLE, // Channel enable state.
  output logic [dmacre_pkg::CHAN_COUNT-1:0] CHAN_REQ_MASK, // Peripheral request mask state.
  output logic [dmacre_pkg::CHAN_COUNT-1:0] SW_REQ_PULSE // Software request pulses.
);
  import dmacre_pkg::*;

  // ----------------------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------------------
  logic rd_capture;
  logic wr_commit;

  dmacre_wb_slave u_wb_slave (
    .CLK(CLK),
    .RST_N(RST_N),
    .cyc_i(CYC_I),
    .stb_i(STB_I),
    .we_i(WE_I),
    .ack_o(ACK_O),
    .rd_capture(rd_capture),
    .wr_commit(wr_commit)
  );

  // ----------------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------------
  logic hit_sw_trigger;
  logic hit_mask_set;
  logic hit_mask_clear;
  logic hit_enable_set;
  logic hit_enable_clear;
  logic hit_flags;
  logic hit_cause;

  assign hit_sw_trigger = (ADR_I == ADDR_SW_REQ_TRIGGER);
  assign hit_mask_set = (ADR_I == ADDR_PREQ_MASK_SET);
  assign hit_mask_clear = (ADR_I == ADDR_PREQ_MASK_CLEAR);
  assign hit_enable_set = (ADR_I == ADDR_CHAN_ENABLE_SET);
  assign hit_enable_clear = (ADR_I == ADDR_CHAN_ENABLE_CLEAR);
  assign hit_flags = (ADR_I == ADDR_AUTO_DIS_FLAGS);
  assign hit_cause = (ADR_I == ADDR_AUTO_DIS_CAUSE);

  // ----------------------------------------------------------------------------
  // Write data with byte lanes applied
  // ----------------------------------------------------------------------------
  // Channel bits 7:0 sit in lane 0 and bits 9:8 in lane 1; upper bits are
  // dropped, so nonzero writes there have no effect.
  logic [CHAN_COUNT-1:0] lane_mask;
  logic [CHAN_COUNT-1:0] wr_ones;

  always_comb begin
    for (int b = 0; b < CHAN_COUNT; b++) begin
      lane_mask[b] = (b < LANE1_FIRST_BIT) ? SEL_I[0] : SEL_I[1];
    end
  end

  assign wr_ones = DAT_I[CHAN_COUNT-1:0] & lane_mask;

  logic [CHAN_COUNT-1:0] wr_sw_trigger;
  logic [CHAN_COUNT-1:0] wr_mask_set;
  logic [CHAN_COUNT-1:0] wr_mask_clear;
  logic [CHAN_COUNT-1:0] wr_enable_set;
  logic [CHAN_COUNT-1:0] wr_enable_clear;
  logic [CHAN_COUNT-1:0] wr_flags_clear;

  assign wr_sw_trigger = {CHAN_COUNT{wr_commit & hit_sw_trigger}} & wr_ones;
  assign wr_mask_set = {CHAN_COUNT{wr_commit & hit_mask_set}} & wr_ones;
  assign wr_mask_clear = {CHAN_COUNT{wr_commit & hit_mask_clear}} & wr_ones;
  assign wr_enable_set = {CHAN_COUNT{wr_commit & hit_enable_set}} & wr_ones;
  assign wr_enable_clear = {CHAN_COUNT{wr_commit & hit_enable_clear}} & wr_ones;
  assign wr_flags_clear = {CHAN_COUNT{wr_commit & hit_flags}} & wr_ones;

  // ----------------------------------------------------------------------------
  // Engine events
  // ----------------------------------------------------------------------------
  // Each event names one channel; a channel number above nine is ignored.
  logic ev_done;
  logic ev_stop;
  logic ev_err;
  logic ev_any;
  logic [CHAN_COUNT-1:0] chan_onehot;
  logic [CHAN_COUNT-1:0] auto_disable;

  assign ev_done = ENGINE_EVT.cycle_done;
  assign ev_stop = ENGINE_EVT.desc_valid & (ENGINE_EVT.desc_ctrl == CYCLE_CTRL_STOP);
  assign ev_err = ENGINE_EVT.bus_err;
  assign ev_any = ev_done | ev_stop | ev_err;

  always_comb begin
    chan_onehot = '0;
    for (int c = 0; c < CHAN_COUNT; c++) begin
      chan_onehot[c] = (ENGINE_EVT.chan == CHAN_W'(c));
    end
  end

  assign auto_disable = {CHAN_COUNT{ev_any}} & chan_onehot;

  // ----------------------------------------------------------------------------
  // Channel cells
  // ----------------------------------------------------------------------------
  logic [CHAN_COUNT-1:0] enable_bits;
  logic [CHAN_COUNT-1:0] mask_bits;
  logic [CHAN_COUNT-1:0] flag_bits;
  logic [CHAN_COUNT-1:0] single_bits;
  logic [CHAN_COUNT-1:0] burst_bits;

  for (genvar g = 0; g < CHAN_COUNT; g++) begin : g_chan
    dmacre_chan_cell u_cell (
      .CLK(CLK),
      .RST_N(RST_N),
      .enable_set(wr_enable_set[g]),
      .enable_clear(wr_enable_clear[g]),
      .auto_disable(auto_disable[g]),
      .mask_set(wr_mask_set[g]),
      .mask_clear(wr_mask_clear[g]),
      .flag_clear(wr_flags_clear[g]),
      .sw_trigger(wr_sw_trigger[g]),
      .periph_single(PERIPH_SINGLE_REQ[g]),
      .periph_burst(PERIPH_BURST_REQ[g]),
      .enable_reg(enable_bits[g]),
      .mask_reg(mask_bits[g]),
      .flag_reg(flag_bits[g]),
      .single_reg(single_bits[g]),
      .burst_reg(burst_bits[g])
    );
  end

  // ----------------------------------------------------------------------------
  // Last auto-disable cause
  // ----------------------------------------------------------------------------
  // A bus error outranks a stop descriptor, which outranks a finished cycle.
  dmacre_cause_t cause_reg;
  dmacre_cause_t cause_next;
  logic [CHAN_W-1:0] cause_chan_reg;

  always_comb begin
    cause_next = cause_reg;
    if (ev_err) begin
      cause_next = DMACRE_CAUSE_BUSERR;
    end else if (ev_stop) begin
      cause_next = DMACRE_CAUSE_STOP;
    end else if (ev_done) begin
      cause_next = DMACRE_CAUSE_DONE;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cause_reg <= DMACRE_CAUSE_NONE;
      cause_chan_reg <= '0;
    end else if (|auto_disable) begin
      cause_reg <= cause_next;
      cause_chan_reg <= ENGINE_EVT.chan;
    end
  end

  // ----------------------------------------------------------------------------
  // Read-back
  // ----------------------------------------------------------------------------
  // Write-only registers and unmapped addresses read as zero.
  logic [DATA_W-1:0] rd_mux;

  always_comb begin
    rd_mux = RST_READ_DATA;
    if (hit_mask_set) begin
      rd_mux[CHAN_COUNT-1:0] = mask_bits;
    end else if (hit_enable_set) begin
      rd_mux[CHAN_COUNT-1:0] = enable_bits;
    end else if (hit_flags) begin
      rd_mux[CHAN_COUNT-1:0] = flag_bits;
    end else if (hit_cause) begin
      rd_mux[CAUSE_LSB +: 2] = cause_reg;
      rd_mux[CAUSE_CHAN_LSB +: CHAN_W] = cause_chan_reg;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      DAT_O <= RST_READ_DATA;
    end else if (rd_capture) begin
      DAT_O <= rd_mux;
    end
  end

  // ----------------------------------------------------------------------------
  // Software request pulse
  // ----------------------------------------------------------------------------
  // Each pulse lasts exactly one cycle after the write edge and is not kept.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      SW_REQ_PULSE <= '0;
    end else begin
      SW_REQ_PULSE <= wr_sw_trigger;
    end
  end

  // ----------------------------------------------------------------------------
  // State outputs
  // ----------------------------------------------------------------------------
  // These flops mirror the cells one cycle later so that every output leaves
  // the top from a register of its own.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      CHAN_ENABLE <= RST_CHAN_ENABLE;
      CHAN_REQ_MASK <= RST_PREQ_MASK;
    end else begin
      CHAN_ENABLE <= enable_bits;
      CHAN_REQ_MASK <= mask_bits;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      CHAN_REQ <= '0;
    end else begin
      CHAN_REQ.single_req <= single_bits;
      CHAN_REQ.burst_req <= burst_bits;
    end
  end

endmodule : dmacre_ctrl

`default_nettype wire

// [verilog/dmacre_pkg.sv]
// Package with register map, field layout and engine event types of the channel control block.
package dmacre_pkg;

  // ----------------------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------------------
  localparam int unsigned CHAN_COUNT = 10;
  localparam int unsigned CHAN_W = 4;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned SEL_W = 4;
  localparam int unsigned CYCLE_CTRL_W = 3;

  // ----------------------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_SW_REQ_TRIGGER = 32'h4003_6014;
  localparam logic [ADDR_W-1:0] ADDR_PREQ_MASK_SET = 32'h4003_6020;
  localparam logic [ADDR_W-1:0] ADDR_PREQ_MASK_CLEAR = 32'h4003_6024;
  localparam logic [ADDR_W-1:0] ADDR_CHAN_ENABLE_SET = 32'h4003_6028;
  localparam logic [ADDR_W-1:0] ADDR_CHAN_ENABLE_CLEAR = 32'h4003_602C;
  localparam logic [ADDR_W-1:0] ADDR_AUTO_DIS_FLAGS = 32'h4003_6040;
  localparam logic [ADDR_W-1:0] ADDR_AUTO_DIS_CAUSE = 32'h4003_6044;

  // ----------------------------------------------------------------------------
  // Reset values and field positions
  // ----------------------------------------------------------------------------
  localparam logic [CHAN_COUNT-1:0] RST_PREQ_MASK = 10'h000;
  localparam logic [CHAN_COUNT-1:0] RST_CHAN_ENABLE = 10'h000;
  localparam logic [CHAN_COUNT-1:0] RST_AUTO_DIS_FLAGS = 10'h000;
  localparam logic [DATA_W-1:0] RST_READ_DATA = 32'h0000_0000;
  localparam int unsigned CAUSE_LSB = 0;
  localparam int unsigned CAUSE_CHAN_LSB = 4;
  localparam int unsigned LANE1_FIRST_BIT = 8;
  localparam logic [CYCLE_CTRL_W-1:0] CYCLE_CTRL_STOP = 3'h0;

  // ----------------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------------
  typedef enum logic [1:0] {
    DMACRE_CAUSE_NONE,
    DMACRE_CAUSE_DONE,
    DMACRE_CAUSE_STOP,
    DMACRE_CAUSE_BUSERR
  } dmacre_cause_t;

  typedef struct packed {
    logic cycle_done;
    logic desc_valid;
    logic [CYCLE_CTRL_W-1:0] desc_ctrl;
    logic bus_err;
    logic [CHAN_W-1:0] chan;
  } dmacre_engine_evt_t;

  typedef struct packed {
    logic [CHAN_COUNT-1:0] single_req;
    logic [CHAN_COUNT-1:0] burst_req;
  } dmacre_req_t;

endpackage : dmacre_pkg

// [verilog/dmacre_wb_slave.sv]
// Classic Wishbone slave handshake: one-cycle registered acknowledge and commit strobes.
`timescale 1ns/1ps
`default_nettype none

module dmacre_wb_slave (
  input wire logic CLK, // System clock.
  input wire logic RST_N, // Asynchronous reset, active low.
  input wire logic cyc_i, // Bus cycle.
  input wire logic stb_i, // Strobe.
  input wire logic we_i, // Write enable.
  output logic ack_o, // Registered acknowledge.
  output logic rd_capture, // Read data must be captured this edge.
  output logic wr_commit // Write takes effect this edge.
);

  logic ack_reg;
  logic ack_next;

  // ----------------------------------------------------------------------------
  // Acknowledge
  // ----------------------------------------------------------------------------
  // The acknowledge rises one edge after the request and falls one edge later.
  always_comb begin
    ack_next = cyc_i & stb_i & ~ack_reg;
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= ack_next;
    end
  end

  // Read data is loaded on the edge that raises the acknowledge, so it is
  // stable while the master samples it; a write lands on the sampling edge.
  assign rd_capture = ack_next & ~we_i;
  assign wr_commit = cyc_i & stb_i & we_i & ack_reg;
  assign ack_o = ack_reg;

endmodule : dmacre_wb_slave

`default_nettype wire
